// ===== hdl/adc_conversion_control.sv
// Converter control: APB registers, conversion sequencer, sleep handling.
//
// Function
// - Six-bit channel field picks the source fed to sample-and-hold.
// - Two-bit field picks positive reference: pin, supply, 2.048V, 4.096V.
// - One bit picks negative reference: pin or ground.
// - A full conversion takes eleven and a half bit periods.
// - Done flag sets on every completion; only software clears it.
// - Completion with interrupt enabled wakes a sleeping device.
// - Format bit picks left or right justified result.
// - Writing go starts a conversion only if enable is already set.
// - Completion clears go, sets flag, loads both result registers.
// - Reset restores all registers and abandons any conversion.
// - With RC clock, start waits one extra instruction cycle.
// - Sleeping, RC, interrupt off: power down after completion, enable kept.
// - Sleep with non-RC clock aborts conversion, powers down, enable kept.
// - Rising edge of chosen trigger sets go in hardware.
// - Five-bit trigger select: 0 off, 1 pin, up to 0x10 peripherals.
// - Triggers are ignored in sleep.
// - Channel code 0x3B is analog ground, 0x3C the temperature sensor.
// - Go is bit 1, enable bit 0 of control 0; go self-clears.
`timescale 1ns/10ps
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Core status.
  input wire logic SLEEP_MODE,
  output logic WAKE_REQ,
  output logic DONE_FLAG,
  // Trigger sources: bit 0 is the remappable pin, bit c-1 for code c.
  input wire logic [15:0] TRIG_IN,
  // Analog side.
  input wire logic RC_OSC,
  input wire logic COMP_HIGH,
  output logic [5:0] CHANNEL_SEL,
  output logic GROUND_SEL,
  output logic TEMP_SEL,
  output logic [1:0] PREF_SEL,
  output logic NREF_SEL,
  output logic CONV_POWER,
  output logic HOLD,
  output logic [9:0] SAR_CODE
);

  conv_timing_if tif ();

  conv_state_t state_ff, nxt_state;
  logic [5:0] chan_ff, nxt_chan;
  logic en_ff, nxt_en;
  logic go_ff, nxt_go;
  logic fmt_ff, nxt_fmt;
  logic [2:0] clks_ff, nxt_clks;
  logic nref_ff, nxt_nref;
  logic [1:0] pref_ff, nxt_pref;
  logic [4:0] trig_ff, nxt_trig;
  logic flag_ff, nxt_flag;
  logic irqen_ff, nxt_irqen;
  logic [7:0] resh_ff, nxt_resh;
  logic [7:0] resl_ff, nxt_resl;
  logic [4:0] ht_ff, nxt_ht;
  logic [3:0] bit_ff, nxt_bit;
  logic [9:0] code_ff, nxt_code;
  logic [2:0] wait_ff, nxt_wait;
  logic pdown_ff, nxt_pdown;
  logic sleep_d_ff;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic wake_ff, nxt_wake;
  logic power_ff, nxt_power;
  logic hold_ff, nxt_hold;
  logic gnd_ff, temp_ff;
  logic trig_pulse;
  logic wr_acc;
  logic is_rc;
  logic done;
  logic [15:0] fmt_res;

  // Places the ten-bit result in the high and low bytes.
  function automatic logic [15:0] format_result(input logic left, input logic [9:0] r);
    format_result = left ? {r[9:2], r[1:0], 6'h00} : {6'h00, r};
  endfunction : format_result

  ////////////////////////////////////////////////////////////////////////////
  // Leaf blocks.
  assign tif.clk_sel = clks_ff;
  assign tif.run = (state_ff == ST_CONV);

  conv_clk_gen u_clk (.clk(CLK), .rst(SYS_RST), .rc_osc(RC_OSC), .tif(tif.gen));

  trig_mux u_trig (
    .clk(CLK),
    .rst(SYS_RST),
    .sel(trig_ff),
    .trig_in(TRIG_IN),
    .sleep(SLEEP_MODE),
    .pulse(trig_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: one access cycle, so every transfer ends two edges after setup.
  assign wr_acc = PSEL & PENABLE & pready_ff & PWRITE;
  assign is_rc = (clks_ff[1:0] == CLKS_RC_LOW);
  assign done = (state_ff == ST_CONV) & tif.half_tick & (ht_ff == (CONV_HALF_TADS - 5'h01));
  assign fmt_res = format_result(fmt_ff, code_ff);

  // Read data is prepared in the setup cycle so it leaves a flip-flop.
  always_comb
  begin
    nxt_pready = PSEL & ~PENABLE;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    if (PSEL && !PENABLE)
    begin
      case (PADDR)
        OFS_CTRL0: nxt_prdata = {24'h00_0000, chan_ff, go_ff, en_ff};
        OFS_CTRL1: nxt_prdata = {24'h00_0000, fmt_ff, clks_ff, 1'b0, nref_ff, pref_ff};
        OFS_TRIG: nxt_prdata = {27'h000_0000, trig_ff};
        OFS_RESH: nxt_prdata = {24'h00_0000, resh_ff};
        OFS_RESL: nxt_prdata = {24'h00_0000, resl_ff};
        OFS_FLAG: nxt_prdata = {31'h0000_0000, flag_ff};
        OFS_IRQEN: nxt_prdata = {31'h0000_0000, irqen_ff};
        default: nxt_pslverr = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and sequencer next state.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    nxt_en = en_ff;
    nxt_go = go_ff;
    nxt_fmt = fmt_ff;
    nxt_clks = clks_ff;
    nxt_nref = nref_ff;
    nxt_pref = pref_ff;
    nxt_trig = trig_ff;
    nxt_irqen = irqen_ff;
    nxt_resh = resh_ff;
    nxt_resl = resl_ff;
    nxt_ht = ht_ff;
    nxt_bit = bit_ff;
    nxt_code = code_ff;
    nxt_wait = wait_ff;
    nxt_pdown = pdown_ff;
    nxt_flag = flag_ff;
    // Software writes; go only ever sets, and only if enable was set before.
    if (wr_acc && (PADDR == OFS_CTRL0))
    begin
      nxt_chan = PWDATA[CHAN_MSB:CHAN_LSB];
      nxt_en = PWDATA[EN_BIT];
      if (PWDATA[GO_BIT] && en_ff)
      begin
        nxt_go = 1'b1;
      end
    end
    if (wr_acc && (PADDR == OFS_CTRL1))
    begin
      nxt_fmt = PWDATA[FMT_BIT];
      nxt_clks = PWDATA[CLKS_MSB:CLKS_LSB];
      nxt_nref = PWDATA[NREF_BIT];
      nxt_pref = PWDATA[PREF_MSB:PREF_LSB];
    end
    if (wr_acc && (PADDR == OFS_TRIG))
    begin
      nxt_trig = PWDATA[TRIG_MSB:0];
    end
    if (wr_acc && (PADDR == OFS_IRQEN))
    begin
      nxt_irqen = PWDATA[IRQEN_BIT];
    end
    // Flag is write-one-to-clear; a completion in the same cycle wins.
    if (wr_acc && (PADDR == OFS_FLAG) && PWDATA[FLAG_BIT])
    begin
      nxt_flag = 1'b0;
    end
    if (trig_pulse && en_ff)
    begin
      nxt_go = 1'b1;
    end
    // Waking up returns the converter to service.
    if (!SLEEP_MODE)
    begin
      nxt_pdown = 1'b0;
    end
    case (state_ff)
      ST_IDLE:
      begin
        if (go_ff && en_ff)
        begin
          nxt_state = is_rc ? ST_WAIT : ST_CONV;
          nxt_wait = 3'h1;
          nxt_ht = 5'h00;
          nxt_bit = SAR_TOP_BIT;
          nxt_code = SAR_START;
        end
      end
      ST_WAIT:
      begin
        // One instruction cycle of grace lets a sleep instruction go first.
        nxt_wait = 3'(wait_ff + 3'h1);
        if (wait_ff == INSTR_CYCLES)
        begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (tif.half_tick)
        begin
          nxt_ht = 5'(ht_ff + 5'h01);
          if (!ht_ff[0] && (ht_ff >= FIRST_DECIDE) && (ht_ff <= LAST_DECIDE))
          begin
            nxt_code[bit_ff] = COMP_HIGH;
            if (bit_ff != 4'h0)
            begin
              nxt_code[bit_ff - 4'h1] = 1'b1;
            end
            nxt_bit = 4'(bit_ff - 4'h1);
          end
        end
        if (done)
        begin
          nxt_state = ST_IDLE;
          nxt_go = 1'b0;
          nxt_flag = 1'b1;
          {nxt_resh, nxt_resl} = fmt_res;
          if (SLEEP_MODE && is_rc && !irqen_ff)
          begin
            nxt_pdown = 1'b1;
          end
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Entering sleep on a system-derived clock kills the conversion outright.
    if (SLEEP_MODE && !sleep_d_ff && !is_rc)
    begin
      nxt_state = ST_IDLE;
      nxt_go = 1'b0;
      nxt_pdown = 1'b1;
    end
    if (!en_ff)
    begin
      nxt_state = ST_IDLE;
      nxt_go = 1'b0;
    end
  end

  // Outputs to the analog side and the core.
  always_comb
  begin
    nxt_wake = flag_ff & irqen_ff & SLEEP_MODE;
    nxt_power = en_ff & ~pdown_ff;
    nxt_hold = (nxt_state == ST_CONV);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers only.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state_ff <= ST_IDLE;
      chan_ff <= CHAN_RST;
      en_ff <= 1'b0;
      go_ff <= 1'b0;
      fmt_ff <= 1'b0;
      clks_ff <= CLKS_RST;
      nref_ff <= 1'b0;
      pref_ff <= PREF_RST;
      trig_ff <= TRIG_RST;
      flag_ff <= 1'b0;
      irqen_ff <= 1'b0;
      {resh_ff, resl_ff} <= {6'h00, RES_RST};
      ht_ff <= 5'h00;
      bit_ff <= SAR_TOP_BIT;
      code_ff <= RES_RST;
      wait_ff <= 3'h0;
      pdown_ff <= 1'b0;
      sleep_d_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      wake_ff <= 1'b0;
      power_ff <= 1'b0;
      hold_ff <= 1'b0;
      gnd_ff <= 1'b0;
      temp_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      chan_ff <= nxt_chan;
      en_ff <= nxt_en;
      go_ff <= nxt_go;
      fmt_ff <= nxt_fmt;
      clks_ff <= nxt_clks;
      nref_ff <= nxt_nref;
      pref_ff <= nxt_pref;
      trig_ff <= nxt_trig;
      flag_ff <= nxt_flag;
      irqen_ff <= nxt_irqen;
      resh_ff <= nxt_resh;
      resl_ff <= nxt_resl;
      ht_ff <= nxt_ht;
      bit_ff <= nxt_bit;
      code_ff <= nxt_code;
      wait_ff <= nxt_wait;
      pdown_ff <= nxt_pdown;
      sleep_d_ff <= SLEEP_MODE;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      wake_ff <= nxt_wake;
      power_ff <= nxt_power;
      hold_ff <= nxt_hold;
      gnd_ff <= (nxt_chan == CHAN_AVSS);
      temp_ff <= (nxt_chan == CHAN_TEMP);
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign WAKE_REQ = wake_ff;
  assign DONE_FLAG = flag_ff;
  assign CHANNEL_SEL = chan_ff;
  assign GROUND_SEL = gnd_ff;
  assign TEMP_SEL = temp_ff;
  assign PREF_SEL = pref_ff;
  assign NREF_SEL = nref_ff;
  assign CONV_POWER = power_ff;
  assign HOLD = hold_ff;
  assign SAR_CODE = code_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Counts half periods from start to check the conversion length.
  logic [5:0] chk_ht_ff;
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || (state_ff != ST_CONV))
      chk_ht_ff <= 6'h00;
    else if (tif.half_tick)
      chk_ht_ff <= 6'(chk_ht_ff + 6'h01);
  end

  property p_chan_route;
    wr_acc && (PADDR == OFS_CTRL0) |=> CHANNEL_SEL == $past(PWDATA[CHAN_MSB:CHAN_LSB]);
  endproperty
  a_chan_route: assert property (p_chan_route) else $error("channel not routed");

  property p_ref_sel;
    wr_acc && (PADDR == OFS_CTRL1) |=> PREF_SEL == $past(PWDATA[PREF_MSB:PREF_LSB])
      && NREF_SEL == $past(PWDATA[NREF_BIT]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong");

  property p_go_needs_en;
    $rose(go_ff) |-> $past(en_ff);
  endproperty
  a_go_needs_en: assert property (p_go_needs_en) else $error("go set while disabled");

  property p_conv_len;
    done |-> chk_ht_ff == 6'(CONV_HALF_TADS - 5'h01);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_done_effects;
    done |=> flag_ff && !go_ff && {resh_ff, resl_ff} == $past(fmt_res);
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("completion effects missing");

  property p_flag_sw_clear;
    $fell(flag_ff) |-> $past(wr_acc && (PADDR == OFS_FLAG) && PWDATA[FLAG_BIT]);
  endproperty
  a_flag_sw_clear: assert property (p_flag_sw_clear) else $error("flag cleared by hardware");

  property p_wake;
    done && irqen_ff && SLEEP_MODE ##1 SLEEP_MODE |=> WAKE_REQ;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on completion");

  property p_sleep_abort;
    SLEEP_MODE && !sleep_d_ff && !is_rc && en_ff ##1 SLEEP_MODE |-> state_ff == ST_IDLE && en_ff ##1 !CONV_POWER;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

  property p_rc_delay;
    state_ff == ST_IDLE && nxt_state == ST_WAIT |=> !tif.run [*4];
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");

endmodule : adc_conversion_control

// ===== pkg/adc_ctrl_pkg.sv
// Shared constants and types for the converter control block.
package adc_ctrl_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_TRIG = 8'h08;
  localparam logic [7:0] OFS_RESH = 8'h0C;
  localparam logic [7:0] OFS_RESL = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h14;
  localparam logic [7:0] OFS_IRQEN = 8'h18;

  // Field positions in converter_control_0.
  localparam int CHAN_MSB = 7;
  localparam int CHAN_LSB = 2;
  localparam int GO_BIT = 1;
  localparam int EN_BIT = 0;

  // Field positions in converter_control_1.
  localparam int FMT_BIT = 7;
  localparam int CLKS_MSB = 6;
  localparam int CLKS_LSB = 4;
  localparam int NREF_BIT = 2;
  localparam int PREF_MSB = 1;
  localparam int PREF_LSB = 0;

  // Other fields.
  localparam int TRIG_MSB = 4;
  localparam int FLAG_BIT = 0;
  localparam int IRQEN_BIT = 0;

  // Reset values.
  localparam logic [5:0] CHAN_RST = 6'h00;
  localparam logic [2:0] CLKS_RST = 3'h0;
  localparam logic [1:0] PREF_RST = 2'h0;
  localparam logic [4:0] TRIG_RST = 5'h00;
  localparam logic [9:0] RES_RST = 10'h000;

  // Channel codes with a special meaning.
  localparam logic [5:0] CHAN_AVSS = 6'h3B;
  localparam logic [5:0] CHAN_TEMP = 6'h3C;

  // Trigger select codes.
  localparam logic [4:0] TRIG_OFF = 5'h00;
  localparam logic [4:0] TRIG_MAX = 5'h10;

  // Conversion timing: half bit periods per conversion and decision window.
  localparam logic [4:0] CONV_HALF_TADS = 5'h17;
  localparam logic [4:0] FIRST_DECIDE = 5'h02;
  localparam logic [4:0] LAST_DECIDE = 5'h14;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;
  localparam logic [9:0] SAR_START = 10'h200;

  // One instruction cycle is four system clocks.
  localparam logic [2:0] INSTR_CYCLES = 3'h4;

  // Clock select codes whose low two bits are both set pick the RC oscillator.
  localparam logic [1:0] CLKS_RC_LOW = 2'h3;

  // Converter sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;

endpackage : adc_ctrl_pkg

// ===== pkg/conv_timing_if.sv
// Carrier between the sequencer and the bit-period generator.
`timescale 1ns/10ps
interface conv_timing_if;
  logic [2:0] clk_sel;
  logic run;
  logic half_tick;

  // The generator makes half bit-period pulses while run is high.
  modport gen (input clk_sel, input run, output half_tick);
  modport ctl (output clk_sel, output run, input half_tick);
endinterface : conv_timing_if

// ===== hdl/conv_clk_gen.sv
// Half bit-period pulse generator from the system clock or the RC oscillator.
`timescale 1ns/10ps
module conv_clk_gen
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Free-running RC oscillator, asynchronous to clk.
  input wire logic rc_osc,
  // Timing carrier.
  conv_timing_if.gen tif
);

  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic rc_s1_ff;
  logic rc_s2_ff;
  logic rc_s3_ff;
  logic tick_ff;
  logic nxt_tick;

  // Half period in system clocks is two to the power of the reordered select.
  function automatic logic [4:0] half_last(input logic [2:0] sel);
    logic [2:0] e;
    logic [5:0] h;
    e = {sel[1:0], sel[2]};
    h = 6'h01 << e;
    half_last = 5'(h - 6'h01);
  endfunction : half_last

  // Divider and RC edge pulse; counting restarts whenever run drops, so the
  // first pulse of a divided-clock conversion comes one full half period after start; with the RC oscillator it comes on the next RC edge.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!tif.run)
    begin
      nxt_cnt = 5'h00;
    end
    else if (tif.clk_sel[1:0] == CLKS_RC_LOW)
    begin
      nxt_tick = rc_s2_ff ^ rc_s3_ff;
    end
    else if (cnt_ff == half_last(tif.clk_sel))
    begin
      nxt_cnt = 5'h00;
      nxt_tick = 1'b1;
    end
    else
    begin
      nxt_cnt = 5'(cnt_ff + 5'h01);
    end
  end

  // Registers; rc_s1 feeds only rc_s2.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff <= 5'h00;
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      rc_s1_ff <= rc_osc;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
      tick_ff <= nxt_tick;
    end
  end

  assign tif.half_tick = tick_ff;

endmodule : conv_clk_gen

// ===== hdl/trig_mux.sv
// Auto-conversion trigger selector and rising-edge detector.
`timescale 1ns/10ps
module trig_mux
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Selection and sources; code c picks trig_in[c-1].
  input wire logic [4:0] sel,
  input wire logic [15:0] trig_in,
  input wire logic sleep,
  // One-cycle pulse on a rising edge of the selected source.
  output logic pulse
);

  logic prev_ff;
  logic pulse_ff;
  logic src;
  logic nxt_pulse;
  logic [4:0] idx;

  // Source pick; reserved codes read as a quiet source. Changing the select
  // while the new source is high looks like an edge, as on any such mux.
  always_comb
  begin
    idx = 5'(sel - 5'h01);
    src = 1'b0;
    if ((sel != TRIG_OFF) && (sel <= TRIG_MAX))
    begin
      src = trig_in[idx[3:0]];
    end
    nxt_pulse = src & ~prev_ff & ~sleep;
  end

  // Edge registers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= src;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse = pulse_ff;

  ////////////////////////////////////////////////////////////////////////////
  // No trigger leaves this block while the device sleeps.
  property p_trig_sleep;
    @(posedge clk) disable iff (rst) sleep |=> !pulse;
  endproperty
  a_trig_sleep: assert property (p_trig_sleep) else $error("trigger in sleep");

endmodule : trig_mux

// ===== test/sar_comparator_model.sv
// Comparator model for the analog side of the converter.
`timescale 1ns/10ps
module sar_comparator_model
(
  // Trial code, hold phase and the held input level.
  input wire logic [9:0] sar_code,
  input wire logic hold,
  input wire logic [9:0] level,
  // Comparator decision.
  output logic comp_high
);
  // Outside the hold phase the output follows a changing pattern, so a stale
  // decision taken there never looks right by luck.
  always_comb
  begin
    comp_high = hold ? (level >= sar_code) : ^sar_code;
  end
endmodule : sar_comparator_model

// ===== test/adc_conversion_control_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module adc_conversion_control_tb;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep = 1'b0;
  logic wake;
  logic done;
  logic [15:0] trig = 16'h0;
  logic rc = 1'b0;
  logic comp;
  logic [5:0] chan;
  logic gnd;
  logic temp;
  logic [1:0] pref;
  logic nref;
  logic pwr;
  logic hold;
  logic [9:0] code;
  logic [9:0] level = 10'h0;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  integer seed = 32'hC2E3;
  integer bad_count = 0;
  integer checked = 0;
  integer c;
  int cyc;

  ////////////////////////////////////////////////////////////////////////////
  // System clock, and a free-running RC oscillator of unrelated phase.
  always #12.5 clk = ~clk;
  always #83 rc = ~rc;

  adc_conversion_control dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLEEP_MODE(sleep),
    .WAKE_REQ(wake), .DONE_FLAG(done), .TRIG_IN(trig), .RC_OSC(rc),
    .COMP_HIGH(comp), .CHANNEL_SEL(chan), .GROUND_SEL(gnd), .TEMP_SEL(temp),
    .PREF_SEL(pref), .NREF_SEL(nref), .CONV_POWER(pwr), .HOLD(hold),
    .SAR_CODE(code));

  sar_comparator_model cmp (.sar_code(code), .hold(hold), .level(level),
    .comp_high(comp));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers.
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // Expected result register contents for either justification.
  function automatic logic [31:0] exp_res(input logic fmt, input logic [9:0] r,
    input logic hi);
    if (fmt)
      return hi ? {24'h0, r[9:2]} : {24'h0, r[1:0], 6'h00};
    return hi ? {30'h0, r[9:8]} : {24'h0, r[7:0]};
  endfunction : exp_res

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
      chk(1'b0, 1'b1, "no ready");
  endtask : apb

  // Waits under a bound for the done flag.
  task automatic wait_done();
    cyc = 0;
    while (done !== 1'b1 && cyc < 3000)
    begin
      @(posedge clk);
      cyc++;
    end
    chk(done, 1'b1, "no completion");
  endtask : wait_done

  task automatic clr_flag();
    apb(1'b1, OFS_FLAG, 32'h1);
    @(negedge clk);
    chk(done, 1'b0, "flag not cleared");
  endtask : clr_flag

  // Software-started conversion of a random level with a given clock.
  task automatic conv(input logic [2:0] cs, input logic fmt);
    int h;
    logic [9:0] lv;
    lv = 10'($random(seed));
    h = 1 << {cs[1:0], cs[2]};
    level <= lv;
    apb(1'b1, OFS_CTRL1, {24'h0, fmt, cs, 4'h0});
    apb(1'b1, OFS_CTRL0, 32'h3);
    wait_done();
    if (cs[1:0] != CLKS_RC_LOW)
      chk(cyc >= 23 * h - 1 && cyc <= 23 * h + 10, 1'b1, "length");
    apb(1'b0, OFS_RESH, 32'h0);
    chk(rd, exp_res(fmt, lv, 1'b1), "result high");
    apb(1'b0, OFS_RESL, 32'h0);
    chk(rd, exp_res(fmt, lv, 1'b0), "result low");
    apb(1'b0, OFS_CTRL0, 32'h0);
    chk(rd[1:0], 2'h1, "go stuck");
    clr_flag();
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (c = 0; c < 7; c++)
    begin
      apb(1'b0, 8'(c * 4), 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    // Go in the same write as enable must not start anything.
    apb(1'b1, OFS_CTRL0, 32'h3);
    repeat (40) @(posedge clk);
    chk(done, 1'b0, "early start");
    for (c = 0; c < 6; c++)
    begin
      v = (c == 0) ? CHAN_AVSS : (c == 1) ? CHAN_TEMP : $random(seed);
      apb(1'b1, OFS_CTRL0, {24'h0, v[5:0], 2'h1});
      apb(1'b1, OFS_CTRL1, {29'h0, v[8:6]});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(chan, v[5:0], "channel");
      chk({gnd, temp}, {v[5:0] == CHAN_AVSS, v[5:0] == CHAN_TEMP}, "decode");
      chk(pref, v[7:6], "pos ref");
      chk(nref, v[8], "neg ref");
    end
    apb(1'b1, OFS_CTRL0, 32'h1);
    for (c = 0; c < 8; c++)
      conv(3'(c), 1'($random(seed)));
    // Trigger codes 0 to 0x11; codes zero and reserved 0x11 stay quiet with all sources pulsing.
    apb(1'b1, OFS_CTRL1, 32'h0);
    for (c = 0; c <= 18; c++)
    begin
      apb(1'b1, OFS_TRIG, (c == 17) ? 32'h1 : (c == 18) ? 32'h11 : 32'(c));
      sleep <= (c == 17);
      trig <= (c == 0 || c == 18) ? 16'hFFFF : 16'h1 << ((c - 1) % 16);
      repeat (3) @(posedge clk);
      trig <= 16'h0;
      if (c == 0 || c >= 17)
      begin
        repeat (40) @(posedge clk);
        chk(done, 1'b0, "stray trigger");
      end
      else
      begin
        wait_done();
        clr_flag();
      end
    end
    sleep <= 1'b0;
    apb(1'b1, OFS_TRIG, 32'h0);
    // Sleep with a divided clock aborts the running conversion.
    apb(1'b1, OFS_CTRL1, 32'h60);
    apb(1'b1, OFS_CTRL0, 32'h3);
    repeat (50) @(posedge clk);
    sleep <= 1'b1;
    repeat (4) @(negedge clk);
    chk(pwr, 1'b0, "not powered down");
    apb(1'b0, OFS_CTRL0, 32'h0);
    chk(rd[1:0], 2'h1, "abort state");
    repeat (800) @(posedge clk);
    chk(done, 1'b0, "aborted flagged");
    sleep <= 1'b0;
    // RC conversions in sleep, interrupt on then off.
    for (c = 1; c >= 0; c--)
    begin
      apb(1'b1, OFS_IRQEN, 32'(c));
      apb(1'b1, OFS_CTRL1, 32'h30);
      apb(1'b1, OFS_CTRL0, 32'h3);
      sleep <= 1'b1;
      repeat (5) @(negedge clk);
      chk(hold, 1'b0, "no start delay");
      @(negedge clk);
      chk(hold, 1'b1, "late start");
      wait_done();
      repeat (3) @(negedge clk);
      chk({wake, pwr}, {2{c[0]}}, "sleep end");
      apb(1'b0, OFS_CTRL0, 32'h0);
      chk(rd[0], 1'b1, "enable lost");
      sleep <= 1'b0;
      clr_flag();
    end
    // Reset in mid-conversion.
    apb(1'b1, OFS_CTRL1, 32'h60);
    apb(1'b1, OFS_CTRL0, 32'h3);
    repeat (30) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({pwr, hold}, 2'h0, "reset power");
    apb(1'b0, OFS_CTRL0, 32'h0);
    chk(rd, 32'h0, "reset ctrl");
    repeat (800) @(posedge clk);
    chk(done, 1'b0, "reset flag");
    end_of_test();
  end

  // Watchdog well beyond the expected run length.
  initial
  begin
    #(25 * 60000);
    bad_count++;
    end_of_test();
  end
endmodule : adc_conversion_control_tb
